// File: cbsi_device.sv
// Card bridge interrupt router with serial interrupt encoder, APB register port.
// Assumes one clock pclk, inputs synchronous to it, and a host end on the shared line.
//
// Functional notes
// - Card interrupts leave on PCI line or ISA.
// - ISA routing enable sends card interrupts to ISA.
// - Function-to-PCI bit moves function interrupt to PCI.
// - Status change goes to its configured ISA IRQ.
// - Serial enable bit repurposes IRQ9 as serial line.
// - IRQ3 strap low at reset release enables serial.
// - Serial mode enables lamp and video outputs.
// - Serial line driven wire-OR by all parties.
// - Cycle is start, data frames, then stop.
// - Suppress bit drops PCI frames after IOCHCK frame.
// - IRQ4 strap low also suppresses PCI frames.
// - Two-bit choice picks the PCI frame used.
// - All serial timing counted in bus clocks.
// - Quiet start: drive low one clock, then float.
// - Continuous start: host pulse 4 to 8 clocks.
// - Stop width two gives quiet, three continuous.
// - Reset into continuous mode, no device starts.
// - Frame n sampled 2+3(n-1) clocks after start.
// - Host may stop after seventeen frames.
// - Idle clocks allowed within the stop frame.
// - Next start may follow turn-around at once.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module cbsi_device
   import cbsi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cbsi_link_if.device link,
   input wire logic card_status_change,
   input wire logic card_func_int,
   input wire logic card_busy,
   input wire logic zv_request,
   input wire logic irq3_strap_n,
   input wire logic irq4_strap_n,
   output logic inta_n,
   output logic [15:0] isa_irq,
   output logic card_activity_lamp,
   output logic zoomed_video_on
);

   // ----------------------------------------------------------------
   // Local types and helpers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_START = 2'b01,
      DS_FRAMES = 2'b10,
      DS_TURN = 2'b11
   } cbsi_dstate_type;

   // One-hot ISA request for an IRQ number when the source is active.
   function automatic logic [15:0] irq_bit(input logic [3:0] num, input logic act);
      return 16'(act) << num;
   endfunction : irq_bit

   logic [7:0] ctrl;
   logic [7:0] route;
   logic strap_taken;
   logic strap3_low;
   logic strap4_low;
   logic serial_irq_mode_on;
   logic pci_frames_suppress;
   logic isa_irq_route_on;
   logic card_func_int_to_pci;
   logic [1:0] pci_frame_choice;
   logic pci_req;
   logic [15:0] isa_vec;
   logic [31:0] frame_vec;
   logic [31:0] reported;
   logic pending;
   cbsi_dstate_type state;
   logic [3:0] low_run;
   logic quiet;
   logic line;
   logic restart;
   logic stop_seen;
   logic mapped;
   logic [4:0] cur_frame;
   logic [4:0] nxt_frame;
   cbsi_phase_type cur_phase;
   cbsi_phase_type nxt_phase;

   // ----------------------------------------------------------------
   // APB register port
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign mapped = (paddr == REG_CTRL) || (paddr == REG_ROUTE) || (paddr == REG_STAT);
   assign pslverr = psel && penable && !mapped;

   // Writable registers update at the access phase; status writes are ignored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         route <= ROUTE_RESET;
      end else if (psel && penable && pwrite) begin
         if (paddr == REG_CTRL) begin
            ctrl <= pwdata[7:0];
         end
         if (paddr == REG_ROUTE) begin
            route <= pwdata[7:0];
         end
      end
   end

   // Read data is loaded in the setup cycle so it stands through the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (paddr)
            REG_CTRL: prdata <= {24'h00_0000, ctrl};
            REG_ROUTE: prdata <= {24'h00_0000, route};
            REG_STAT: prdata <= {26'h0, pending, state != DS_IDLE, strap4_low, strap3_low,
                                 quiet, serial_irq_mode_on};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Straps and mode selection
   // ----------------------------------------------------------------
   // Straps are caught by the first clock after reset release, never by the reset itself.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_taken <= 1'b0;
         strap3_low <= 1'b0;
         strap4_low <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap3_low <= !irq3_strap_n;
         strap4_low <= !irq4_strap_n;
      end
   end

   // Effective mode bits from registers and straps.
   assign serial_irq_mode_on = ctrl[CTRL_SERIAL] || strap3_low;
   assign pci_frames_suppress = ctrl[CTRL_SUPPRESS] || strap4_low;
   assign isa_irq_route_on = ctrl[CTRL_ISA_ROUTE];
   assign card_func_int_to_pci = ctrl[CTRL_FUNC_PCI];
   assign pci_frame_choice = ctrl[CTRL_CHOICE_LO +: 2];

   // ----------------------------------------------------------------
   // Interrupt routing
   // ----------------------------------------------------------------
   // Status change follows the ISA enable; function interrupt may be pulled back to PCI.
   assign pci_req = (card_status_change && !isa_irq_route_on) ||
                    (card_func_int && !(isa_irq_route_on && !card_func_int_to_pci));
   assign isa_vec = irq_bit(route[ROUTE_CSC_LO +: 4], card_status_change && isa_irq_route_on) |
                    irq_bit(route[ROUTE_FUNC_LO +: 4],
                            card_func_int && isa_irq_route_on && !card_func_int_to_pci);

   // Pin outputs; in serial mode ISA requests travel as frames and the pins rest.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inta_n <= 1'b1;
         isa_irq <= 16'h0000;
         card_activity_lamp <= 1'b0;
         zoomed_video_on <= 1'b0;
      end else begin
         inta_n <= !pci_req;
         isa_irq <= serial_irq_mode_on ? 16'h0000 : isa_vec;
         card_activity_lamp <= serial_irq_mode_on && card_busy;
         zoomed_video_on <= serial_irq_mode_on && zv_request;
      end
   end

   // Frame image: ISA IRQs, empty SMI and IOCHCK frames, one chosen PCI frame.
   always_comb begin
      frame_vec = 32'h0000_0000;
      frame_vec[15:0] = isa_vec;
      frame_vec[SER_SMI_FRAME] = 1'b0;
      if (!pci_frames_suppress) begin
         frame_vec[SER_PCI_FRAME0 + int'(pci_frame_choice)] = pci_req;
      end
   end

   // ----------------------------------------------------------------
   // Serial encoder
   // ----------------------------------------------------------------
   assign line = link.serial_irq_line;
   assign pending = frame_vec != reported;
   assign stop_seen = (!line && low_run != 4'h0) || low_run >= 4'(STOP_QUIET);
   assign restart = (state == DS_START) && line && low_run != 4'h0 &&
                    (quiet || (low_run >= 4'(START_MIN) && low_run <= 4'(START_MAX)));

   cbsi_slot_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .restart(restart),
      .cur_frame(cur_frame),
      .cur_phase(cur_phase),
      .nxt_frame(nxt_frame),
      .nxt_phase(nxt_phase)
   );

   // Run length of consecutive low samples on the line, saturating.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_run <= 4'h0;
      end else if (!line) begin
         low_run <= (low_run == 4'hf) ? low_run : low_run + 4'h1;
      end else begin
         low_run <= 4'h0;
      end
   end

   // Cycle sequencer: start, data frames until a stop pulse, one turn-around.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= DS_IDLE;
         quiet <= 1'b0;
         reported <= 32'h0000_0000;
      end else if (!serial_irq_mode_on) begin
         state <= DS_IDLE;
      end else begin
         unique case (state)
            DS_IDLE: begin
               if (!line || (quiet && pending)) begin
                  state <= DS_START;
               end
            end
            DS_START: begin
               if (restart) begin
                  state <= DS_FRAMES;
                  reported <= frame_vec;
               end else if (line && low_run != 4'h0) begin
                  state <= DS_IDLE;
               end
            end
            DS_FRAMES: begin
               if (line && low_run >= 4'(STOP_QUIET)) begin
                  state <= DS_TURN;
                  if (low_run == 4'(STOP_QUIET)) begin
                     quiet <= 1'b1;
                  end else if (low_run == 4'(STOP_CONT)) begin
                     quiet <= 1'b0;
                  end
               end
            end
            DS_TURN: begin
               state <= DS_IDLE;
            end
         endcase
      end
   end

   // Line drive for the coming cycle: own quiet start pulse and frame bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.dev_drive <= 1'b0;
         link.dev_level <= 1'b1;
      end else begin
         link.dev_drive <= 1'b0;
         link.dev_level <= 1'b1;
         if (serial_irq_mode_on && state == DS_IDLE && line && quiet && pending) begin
            link.dev_drive <= 1'b1;
            link.dev_level <= 1'b0;
         end else if (serial_irq_mode_on && state == DS_FRAMES && !stop_seen &&
                      reported[nxt_frame]) begin
            if (nxt_phase == PH_SAMPLE) begin
               link.dev_drive <= 1'b1;
               link.dev_level <= 1'b0;
            end else if (nxt_phase == PH_RECOVER) begin
               link.dev_drive <= 1'b1;
               link.dev_level <= 1'b1;
            end
         end
      end
   end

endmodule : cbsi_device
`default_nettype wire

// File: cbsi_pkg.sv
// Shared constants, types and slot decoding for the serial interrupt router.
// Assumes one clock (pclk, 50 MHz) on both ends of the serial line.
package cbsi_pkg;

   // ----------------------------------------------------------------
   // Register offsets, fields and reset values of the device end
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ROUTE = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam int CTRL_ISA_ROUTE = 0;
   localparam int CTRL_CHOICE_LO = 3;
   localparam int CTRL_SUPPRESS = 5;
   localparam int CTRL_FUNC_PCI = 6;
   localparam int CTRL_SERIAL = 7;
   localparam int ROUTE_CSC_LO = 0;
   localparam int ROUTE_FUNC_LO = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ROUTE_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Serial frame timing in clock cycles
   // ----------------------------------------------------------------
   localparam int SER_FIRST_SAMPLE = 2;
   localparam int SER_FRAME_CLKS = 3;
   localparam int SER_FRAMES = 32;
   localparam int SER_ISA_FRAMES = 17;
   localparam int SER_ALL_FRAMES = 21;
   localparam int SER_PCI_FRAME0 = 17;
   localparam int SER_SMI_FRAME = 2;
   localparam int START_MIN = 4;
   localparam int START_MAX = 8;
   localparam int STOP_QUIET = 2;
   localparam int STOP_CONT = 3;
   localparam int SER_LAST_T = SER_FIRST_SAMPLE + SER_FRAME_CLKS * SER_FRAMES;

   // Position of a cycle inside its frame.
   typedef enum logic [1:0] {
      PH_SAMPLE = 2'b00,
      PH_RECOVER = 2'b01,
      PH_TURN = 2'b10,
      PH_NONE = 2'b11
   } cbsi_phase_type;

   // Phase of the cycle that lies t cycles after the start frame.
   function automatic cbsi_phase_type cbsi_phase(input logic [6:0] t);
      int d;
      d = int'(t) - SER_FIRST_SAMPLE;
      if (d < 0 || int'(t) >= SER_LAST_T) begin
         return PH_NONE;
      end
      return cbsi_phase_type'(2'(d % SER_FRAME_CLKS));
   endfunction : cbsi_phase

   // Zero-based frame index of the cycle t cycles after the start frame.
   function automatic logic [4:0] cbsi_frame(input logic [6:0] t);
      int d;
      d = int'(t) - SER_FIRST_SAMPLE;
      if (d < 0 || int'(t) >= SER_LAST_T) begin
         return 5'h00;
      end
      return 5'(d / SER_FRAME_CLKS);
   endfunction : cbsi_frame

endpackage : cbsi_pkg

// File: cbsi_link_if.sv
// Shared serial interrupt line between the device end and the host end.
// Each party gives a drive enable and a level; any low drive wins, else a pull-up holds it high.
`timescale 1ns/1ns
`default_nettype none
interface cbsi_link_if;

   logic dev_drive;
   logic dev_level;
   logic host_drive;
   logic host_level;
   logic serial_irq_line;

   // Wire-OR resolution: low is dominant, released line floats high.
   assign serial_irq_line = !((dev_drive && !dev_level) || (host_drive && !host_level));

   modport device (output dev_drive, output dev_level, input serial_irq_line);
   modport host (output host_drive, output host_level, input serial_irq_line);

endinterface : cbsi_link_if
`default_nettype wire

// File: cbsi_slot_timer.sv
// Counts cycles after a recognised start frame and decodes frame and phase.
// Assumes restart pulses at the edge that ends the start frame's recovery cycle.
`timescale 1ns/1ns
`default_nettype none
module cbsi_slot_timer
   import cbsi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   output logic [4:0] cur_frame,
   output cbsi_phase_type cur_phase,
   output logic [4:0] nxt_frame,
   output cbsi_phase_type nxt_phase
);

   logic [6:0] cnt;
   logic [6:0] next_cnt;

   // Zero means idle; counting saturates past the last frame.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 7'h00;
      end else if (restart) begin
         cnt <= 7'h01;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Value of the count in the coming cycle when nothing restarts it.
   always_comb begin
      if (cnt == 7'h00 || cnt == 7'h7f) begin
         next_cnt = cnt;
      end else begin
         next_cnt = cnt + 7'h01;
      end
   end

   // Decode of the present and the coming cycle.
   assign cur_frame = cbsi_frame(cnt);
   assign cur_phase = cbsi_phase(cnt);
   assign nxt_frame = cbsi_frame(next_cnt);
   assign nxt_phase = cbsi_phase(next_cnt);

endmodule : cbsi_slot_timer
`default_nettype wire

// File: cbsi_host.sv
// Host end of the serial interrupt line: starts cycles, samples frames, ends with a stop.
// Assumes one clock pclk and a device end sharing the line through the link interface.
`timescale 1ns/1ns
`default_nettype none
module cbsi_host
   import cbsi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   cbsi_link_if.host link,
   input wire logic start_req,
   input wire logic use_quiet,
   input wire logic all_frames,
   input wire logic [3:0] start_width,
   output logic [31:0] irq_state,
   output logic cycle_done,
   output logic busy
);

   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_START = 3'b001,
      HS_START_REC = 3'b010,
      HS_FRAMES = 3'b011,
      HS_STOP = 3'b100,
      HS_STOP_REC = 3'b101,
      HS_TURN = 3'b110
   } cbsi_hstate_type;

   cbsi_hstate_type state;
   logic [3:0] cnt_w;
   logic [3:0] width;
   logic [3:0] stop_w;
   logic host_quiet;
   logic line;
   logic [4:0] last_frame;
   logic [4:0] cur_frame;
   logic [4:0] nxt_frame;
   cbsi_phase_type cur_phase;
   cbsi_phase_type nxt_phase;

   // ----------------------------------------------------------------
   // Settings of the coming cycle
   // ----------------------------------------------------------------
   assign line = link.serial_irq_line;
   assign busy = state != HS_IDLE;
   assign width = (start_width < 4'(START_MIN)) ? 4'(START_MIN) :
                  (start_width > 4'(START_MAX)) ? 4'(START_MAX) : start_width;
   assign stop_w = host_quiet ? 4'(STOP_QUIET) : 4'(STOP_CONT);
   assign last_frame = all_frames ? 5'(SER_ALL_FRAMES) : 5'(SER_ISA_FRAMES);

   cbsi_slot_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .restart(state == HS_START_REC),
      .cur_frame(cur_frame),
      .cur_phase(cur_phase),
      .nxt_frame(nxt_frame),
      .nxt_phase(nxt_phase)
   );

   // ----------------------------------------------------------------
   // Cycle sequencer and line drive
   // ----------------------------------------------------------------
   // Drives start pulse, recovery and stop pulse; floats everywhere else.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= HS_IDLE;
         cnt_w <= 4'h0;
         host_quiet <= 1'b0;
         cycle_done <= 1'b0;
         link.host_drive <= 1'b0;
         link.host_level <= 1'b1;
      end else begin
         cycle_done <= 1'b0;
         unique case (state)
            HS_IDLE: begin
               if (start_req || (host_quiet && !line)) begin
                  state <= HS_START;
                  cnt_w <= (host_quiet && !line) ? 4'h2 : 4'h1;
                  link.host_drive <= 1'b1;
                  link.host_level <= 1'b0;
               end
            end
            HS_START: begin
               if (cnt_w < width) begin
                  cnt_w <= cnt_w + 4'h1;
               end else begin
                  state <= HS_START_REC;
                  link.host_level <= 1'b1;
               end
            end
            HS_START_REC: begin
               state <= HS_FRAMES;
               link.host_drive <= 1'b0;
            end
            HS_FRAMES: begin
               if (nxt_phase == PH_SAMPLE && nxt_frame == last_frame) begin
                  state <= HS_STOP;
                  cnt_w <= 4'h1;
                  host_quiet <= use_quiet;
                  link.host_drive <= 1'b1;
                  link.host_level <= 1'b0;
               end
            end
            HS_STOP: begin
               if (cnt_w < stop_w) begin
                  cnt_w <= cnt_w + 4'h1;
               end else begin
                  state <= HS_STOP_REC;
                  link.host_level <= 1'b1;
               end
            end
            HS_STOP_REC: begin
               state <= HS_TURN;
               link.host_drive <= 1'b0;
            end
            HS_TURN: begin
               state <= HS_IDLE;
               cycle_done <= 1'b1;
            end
            default: begin
               state <= HS_IDLE;
               link.host_drive <= 1'b0;
            end
         endcase
      end
   end

   // Frame samples, active high; cleared as a new cycle begins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_state <= 32'h0000_0000;
      end else if (state == HS_START_REC) begin
         irq_state <= 32'h0000_0000;
      end else if (state == HS_FRAMES && cur_phase == PH_SAMPLE) begin
         irq_state[cur_frame] <= !line;
      end
   end

endmodule : cbsi_host
`default_nettype wire

// File: cbsi_sva.sv
// Checker for the shared serial interrupt line between the device and host ends.
// Assumes its inputs are the link interface signals, instantiated beside that interface.
`timescale 1ns/1ns
`default_nettype none
module cbsi_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic dev_drive,
   input wire logic dev_level,
   input wire logic host_drive,
   input wire logic host_level,
   input wire logic serial_irq_line
);
   // ----------------------------------------------------------------
   // Drive relations on the line
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Low drives of each end, used by several properties.
   wire logic dev_low = dev_drive && !dev_level;
   wire logic host_low = host_drive && !host_level;
   wire_or_level_a: assert property (serial_irq_line == !(dev_low || host_low))
      else $error("line level differs from the resolved drives");
   dev_one_low_a: assert property (dev_low |=> !dev_low)
      else $error("device drove low for more than one clock");
   dev_rec_float_a: assert property (dev_drive && dev_level |=> !dev_drive)
      else $error("device did not float after its recovery clock");
   dev_high_cause_a: assert property (dev_drive && dev_level |-> $past(dev_low))
      else $error("device drove high without a low clock before");
   host_low_max_a: assert property (host_low [*8] |=> !host_low)
      else $error("host low pulse longer than eight clocks");
   host_low_min_a: assert property ($rose(host_low) |=> host_low)
      else $error("host low pulse shorter than two clocks");
   host_rec_high_a: assert property (host_low ##1 !host_low |-> host_drive && host_level)
      else $error("host pulse not followed by a recovery high");
   host_turn_a: assert property (host_drive && host_level |=> !host_drive)
      else $error("host did not float after its recovery clock");
endmodule : cbsi_sva
`default_nettype wire

// File: cbsi_tb.sv
// Self-checking bench joining the device end and host end over the link interface.
// Assumes the package constants and a 50 MHz pclk; checker sits beside the interface.
`timescale 1ns/1ns
`default_nettype none
module cbsi_tb
   import cbsi_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ctrl, route;
   logic [31:0] pwdata = 32'h0, prdata, rd, irq_state;
   logic pready, pslverr, er, inta_n, lamp, video, cycle_done, busy;
   logic csc = 1'b0, func = 1'b0, cbusy = 1'b0, zv = 1'b0, s3 = 1'b1, s4 = 1'b1;
   logic start_req = 1'b0, use_quiet = 1'b0, all_frames = 1'b0;
   logic [3:0] start_width = 4'h4;
   logic [15:0] isa_irq;
   int mismatches = 0, checks_done = 0, seed = 8832, n;
   cbsi_link_if link ();
   cbsi_device i_cbsi_device (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.device), .card_status_change(csc), .card_func_int(func),
      .card_busy(cbusy), .zv_request(zv), .irq3_strap_n(s3), .irq4_strap_n(s4), .inta_n(inta_n),
      .isa_irq(isa_irq), .card_activity_lamp(lamp), .zoomed_video_on(video));
   cbsi_host i_cbsi_host (.pclk(pclk), .presetn(presetn), .link(link.host), .start_req(start_req),
      .use_quiet(use_quiet), .all_frames(all_frames), .start_width(start_width),
      .irq_state(irq_state), .cycle_done(cycle_done), .busy(busy));
   cbsi_sva i_cbsi_sva (.pclk(pclk), .presetn(presetn), .dev_drive(link.dev_drive),
      .dev_level(link.dev_level), .host_drive(link.host_drive), .host_level(link.host_level),
      .serial_irq_line(link.serial_irq_line));
   // ----------------------------------------------------------------
   // Clock, checks and expectations
   // ----------------------------------------------------------------
   // Free running 50 MHz clock.
   always #10 pclk = ~pclk;
   // Compares one value and counts it.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   // One APB transfer: setup, then access until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Whether the card interrupts ask for the PCI line.
   function automatic logic pci_req();
      return (csc & !ctrl[0]) | (func & !(ctrl[0] & !ctrl[6]));
   endfunction : pci_req
   // ISA pins expected while serial mode is off.
   function automatic logic [15:0] isa_exp();
      logic [15:0] v;
      v = 16'h0000;
      if (csc & ctrl[0]) v[route[3:0]] = 1'b1;
      if (func & ctrl[0] & !ctrl[6]) v[route[7:4]] = 1'b1;
      return v;
   endfunction : isa_exp
   // Frame image the host should report; the SMI slot never carries IRQ2.
   function automatic logic [31:0] frm_exp(input logic a);
      logic [31:0] v;
      v = {16'h0000, isa_exp() & 16'hfffb};
      if (pci_req() & !ctrl[5] & s4 & a) v[17 + ctrl[4:3]] = 1'b1;
      return v;
   endfunction : frm_exp
   // One serial cycle, started by the host when req is set, checked at its end.
   task automatic ser(input logic q, input logic req);
      logic a;
      @(posedge pclk);
      a = 1'($random(seed));
      all_frames <= a;
      use_quiet <= q;
      start_width <= 4'(4 + $unsigned($random(seed)) % 5);
      start_req <= req;
      @(posedge pclk);
      start_req <= 1'b0;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (cycle_done !== 1'b1 && n < 400);
      check("cycle end", {31'h0, cycle_done}, 32'h1);
      check("frames", irq_state, frm_exp(a));
   endtask : ser
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      finish_test();
   end
   // Works through reset, routing, serial cycles and the strap reset.
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      check("unmapped error", {31'h0, er}, 32'h1);
      repeat (40) begin
         ctrl = 8'($random(seed)) & 8'h79;
         route = 8'($random(seed));
         apb(1'b1, 8'h00, {24'h0, ctrl});
         apb(1'b1, 8'h04, {24'h0, route});
         apb(1'b0, 8'h00, 32'h0);
         check("ctrl", rd, {24'h0, ctrl});
         csc <= 1'($random(seed));
         func <= 1'($random(seed));
         repeat (3) @(posedge pclk);
         @(negedge pclk);
         check("inta", {31'h0, inta_n}, {31'h0, !pci_req()});
         check("isa pins", {16'h0, isa_irq}, {16'h0, isa_exp()});
      end
      ctrl = 8'h81;
      apb(1'b1, 8'h00, {24'h0, ctrl});
      func <= 1'b1;
      cbusy <= 1'b1;
      n = 0;
      repeat (200) begin
         @(posedge pclk);
         n += int'(link.dev_drive);
      end
      check("no device start", {31'h0, busy}, 32'h0);
      check("device idle", n, 32'h0);
      check("lamp", {31'h0, lamp}, 32'h1);
      check("serial isa off", {16'h0, isa_irq}, 32'h0);
      for (int k = 0; k < 8; k++) begin
         ctrl = 8'h80 | 8'(k[1:0]) << 3 | 8'(k[2]) << 5 | (8'($random(seed)) & 8'h41);
         route = 8'($random(seed));
         apb(1'b1, 8'h00, {24'h0, ctrl});
         apb(1'b1, 8'h04, {24'h0, route});
         csc <= 1'($random(seed));
         func <= 1'($random(seed));
         ser(1'b0, 1'b1);
      end
      ctrl = 8'h80;
      apb(1'b1, 8'h00, {24'h0, ctrl});
      csc <= 1'b0;
      ser(1'b1, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check("quiet mode", {31'h0, rd[1]}, 32'h1);
      func <= !func;
      ser(1'b1, 1'b0);
      ser(1'b0, 1'b1);
      @(posedge pclk);
      presetn <= 1'b0;
      s3 <= 1'b0;
      s4 <= 1'b0;
      zv <= 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      ctrl = 8'h00;
      func <= 1'b1;
      apb(1'b0, 8'h08, 32'h0);
      check("strap status", {28'h0, rd[3:0] & 4'hd}, 32'hd);
      check("video", {31'h0, video}, 32'h1);
      ser(1'b0, 1'b1);
      finish_test();
   end
endmodule : cbsi_tb
`default_nettype wire
